// ==== dopwg_core.sv ====
/*
 * dual output waveform generator: one up/down counter drives two
 * complementary outputs in four ramp, two ramp, one ramp or center
 * aligned mode, with coherent update at cycle end (at the counter top
 * in center aligned mode) and 16 cycle fractional lengthening.
 * assumes: a register master on the plain strobe port, synchronous
 * to sys_clk_i; outputs go to external power switch drivers.
 */
`timescale 1ns/1ns
`include "dopwg_defines.svh"

module dopwg_core (
    // clock and reset
    input  wire logic                sys_clk_i,
    input  wire logic                rst_n_i,
    // register port
    input  wire dopwg_pkg::dopwg_addr_t reg_addr_i,
    input  wire dopwg_pkg::dopwg_word_t reg_wdata_i,
    input  wire logic                reg_wr_i,
    input  wire logic                reg_rd_i,
    output      dopwg_pkg::dopwg_word_t reg_rdata_o,
    // power stage outputs
    output      logic                output_a_o,
    output      logic                output_b_o
);
    import dopwg_pkg::*;

    // ==========================================================
    // state
    dopwg_state_t st_r;
    dopwg_state_t st_nxt;

    logic [11:0] sa;
    logic [11:0] sb;
    logic [11:0] rb;
    logic [11:0] ra_eff;
    logic [3:0]  frac;
    logic [3:0]  slot_rev;
    logic [12:0] top;
    logic [12:0] thr;
    logic        ctr;
    logic        split;
    logic        at_top;
    logic        lengthen;
    logic        hold;
    logic        cyc_end;
    logic        upd_pt;
    logic        allow;
    logic        load;
    logic        wave_a;
    logic        wave_b;

    // ==========================================================
    // active timing values
    // fifty follows the config bit at once, not only at the next load
    assign sa = st_r.fifty ? st_r.act_sb[`DOPWG_VAL_HI:0]
                           : st_r.act_sa[`DOPWG_VAL_HI:0];
    assign sb = st_r.act_sb[`DOPWG_VAL_HI:0];
    assign rb = st_r.act_rb[`DOPWG_VAL_HI:0];
    // reset-a is not part of the synced set, so it is used as written
    assign ra_eff = st_r.fifty ? rb : st_r.ra;
    assign frac = st_r.act_rb[`DOPWG_FRAC_HI:`DOPWG_FRAC_LO];

    assign ctr   = (st_r.mode == MODE_CENTER);
    assign split = (st_r.mode == MODE_FOUR) || (st_r.mode == MODE_TWO);

    // ==========================================================
    // ramp top and threshold of the current ramp
    always_comb begin
        top = {1'b0, rb};
        thr = {1'b0, sb};
        unique case (st_r.mode)
            MODE_FOUR: begin
                // dead part spans set+2 counts, on part the reset count
                if (st_r.phase_b) begin
                    top = {1'b0, sb} + {1'b0, rb} + `DOPWG_ONE;
                    thr = {1'b0, sb} + `DOPWG_ONE;
                end else begin
                    top = {1'b0, sa} + {1'b0, ra_eff} + `DOPWG_ONE;
                    thr = {1'b0, sa} + `DOPWG_ONE;
                end
            end
            MODE_TWO: begin
                // each half cycle is a ramp from zero to reset
                if (st_r.phase_b) begin
                    top = {1'b0, rb};
                    thr = {1'b0, sb};
                end else begin
                    top = {1'b0, ra_eff};
                    thr = {1'b0, sa};
                end
            end
            MODE_ONE: begin
                top = {1'b0, rb};
                thr = {1'b0, sb};
            end
            MODE_CENTER: begin
                top = {1'b0, rb};
                thr = {1'b0, sb};
            end
        endcase
    end

    assign at_top = (st_r.cnt == top);

    // ==========================================================
    // fractional lengthening
    // slot order by bit reversal gives 0,8,4,12,2,... as d rises
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_rev
            assign slot_rev[gi] = st_r.slot[3 - gi];
        end
    endgenerate

    assign lengthen = st_r.enh && (slot_rev < frac);
    // the extra count is a held zero at cycle start: dead time a, except in center mode where a is on below set-a
    assign hold = st_r.run && lengthen && !st_r.stretched &&
                  (st_r.cnt == `DOPWG_CNT_ZERO) && !st_r.phase_b &&
                  !st_r.down;

    // ==========================================================
    // cycle end and update point
    assign cyc_end = st_r.run && !hold &&
                     (ctr ? (st_r.down && (st_r.cnt == `DOPWG_CNT_ZERO))
                          : (at_top && (!split || st_r.phase_b)));
    assign upd_pt = ctr ? (st_r.run && !st_r.down && at_top)
                        : cyc_end;
    assign allow = st_r.alock_eff ? st_r.last_rb : !st_r.lock;
    // while stopped the pending set is taken at once
    assign load = st_r.dirty && (!st_r.run || (upd_pt && allow));

    // ==========================================================
    // waveforms
    always_comb begin
        wave_a = 1'b0;
        wave_b = 1'b0;
        unique case (st_r.mode)
            MODE_CENTER: begin
                wave_a = (st_r.cnt < {1'b0, sa});
                wave_b = (st_r.cnt >= {1'b0, sb});
            end
            MODE_ONE: begin
                wave_a = (st_r.cnt > {1'b0, sa}) &&
                         (st_r.cnt <= {1'b0, ra_eff});
                wave_b = (st_r.cnt > {1'b0, sb});
            end
            MODE_FOUR, MODE_TWO: begin
                wave_a = !st_r.phase_b && (st_r.cnt > thr);
                wave_b = st_r.phase_b && (st_r.cnt > thr);
            end
        endcase
    end

    // ==========================================================
    // next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.rdata = 16'h0000;

        // counter
        if (!st_r.run) begin
            st_nxt.cnt       = `DOPWG_CNT_ZERO;
            st_nxt.phase_b   = 1'b0;
            st_nxt.down      = 1'b0;
            st_nxt.stretched = 1'b0;
        end else if (hold) begin
            st_nxt.stretched = 1'b1;
        end else if (ctr) begin
            if (!st_r.down) begin
                if (at_top) begin
                    st_nxt.down = 1'b1;
                end else begin
                    st_nxt.cnt = st_r.cnt + `DOPWG_ONE;
                end
            end else begin
                if (st_r.cnt == `DOPWG_CNT_ZERO) begin
                    st_nxt.down = 1'b0;
                end else begin
                    st_nxt.cnt = st_r.cnt - `DOPWG_ONE;
                end
            end
        end else if (at_top) begin
            st_nxt.cnt = `DOPWG_CNT_ZERO;
            if (split) begin
                st_nxt.phase_b = !st_r.phase_b;
            end
        end else begin
            st_nxt.cnt = st_r.cnt + `DOPWG_ONE;
        end

        if (cyc_end) begin
            st_nxt.slot      = st_r.slot + `DOPWG_SLOT_STEP;
            st_nxt.stretched = 1'b0;
            st_nxt.alock_eff = st_r.alock;
        end

        // coherent transfer of the whole pending set
        if (load) begin
            st_nxt.act_sa   = st_r.fifty ? st_r.pend_sb : st_r.pend_sa;
            st_nxt.act_sb   = st_r.pend_sb;
            st_nxt.act_rb   = st_r.pend_rb;
            st_nxt.act_ocfg = st_r.pend_ocfg;
            st_nxt.act_mtx  = st_r.pend_mtx;
            st_nxt.dirty    = 1'b0;
            st_nxt.last_rb  = 1'b0;
        end

        // register writes come after the load so a new write stays pending
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                `DOPWG_A_SET_A: begin
                    st_nxt.pend_sa = reg_wdata_i;
                    st_nxt.dirty   = 1'b1;
                    st_nxt.last_rb = 1'b0;
                end
                `DOPWG_A_RST_A: begin
                    st_nxt.ra = reg_wdata_i[`DOPWG_VAL_HI:0];
                end
                `DOPWG_A_SET_B: begin
                    st_nxt.pend_sb = reg_wdata_i;
                    st_nxt.dirty   = 1'b1;
                    st_nxt.last_rb = 1'b0;
                end
                `DOPWG_A_RST_B: begin
                    st_nxt.pend_rb = reg_wdata_i;
                    st_nxt.dirty   = 1'b1;
                    st_nxt.last_rb = 1'b1;
                end
                `DOPWG_A_CFG: begin
                    st_nxt.mode  = dopwg_mode_t'(reg_wdata_i[`DOPWG_MODE_HI:0]);
                    st_nxt.fifty = reg_wdata_i[`DOPWG_C_FIFTY];
                    st_nxt.enh   = reg_wdata_i[`DOPWG_C_ENH];
                    st_nxt.lock  = reg_wdata_i[`DOPWG_C_LOCK];
                    st_nxt.alock = reg_wdata_i[`DOPWG_C_ALOCK];
                    st_nxt.pol   = reg_wdata_i[`DOPWG_C_POL];
                    st_nxt.run   = reg_wdata_i[`DOPWG_C_RUN];
                end
                `DOPWG_A_OCFG: begin
                    st_nxt.pend_ocfg = reg_wdata_i[`DOPWG_OCFG_HI:0];
                    st_nxt.dirty     = 1'b1;
                    st_nxt.last_rb   = 1'b0;
                end
                `DOPWG_A_MTX: begin
                    st_nxt.pend_mtx = reg_wdata_i[`DOPWG_MTX_HI:0];
                    st_nxt.dirty    = 1'b1;
                    st_nxt.last_rb  = 1'b0;
                end
                `DOPWG_A_STAT: begin
                    st_nxt.dirty = st_nxt.dirty;
                end
            endcase
        end

        // read data stands only in the cycle after the strobe
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                `DOPWG_A_SET_A: st_nxt.rdata = st_r.pend_sa;
                `DOPWG_A_RST_A: st_nxt.rdata = {4'h0, st_r.ra};
                `DOPWG_A_SET_B: st_nxt.rdata = st_r.pend_sb;
                `DOPWG_A_RST_B: st_nxt.rdata = st_r.pend_rb;
                `DOPWG_A_CFG: begin
                    st_nxt.rdata = {8'h00, st_r.run, st_r.pol, st_r.alock,
                                    st_r.lock, st_r.enh, st_r.fifty,
                                    st_r.mode};
                end
                `DOPWG_A_OCFG: st_nxt.rdata = {14'h0000, st_r.act_ocfg};
                `DOPWG_A_MTX: st_nxt.rdata = {12'h000, st_r.act_mtx};
                `DOPWG_A_STAT: begin
                    st_nxt.rdata = {st_r.dirty, st_r.down, st_r.phase_b,
                                    st_r.cnt};
                end
            endcase
        end

        // outputs: disabled or stopped means inactive level
        st_nxt.out_a = (wave_a && st_r.run && st_r.act_ocfg[`DOPWG_O_A])
                       ^ st_r.pol;
        st_nxt.out_b = (wave_b && st_r.run && st_r.act_ocfg[`DOPWG_O_B])
                       ^ st_r.pol;
    end

    // ==========================================================
    // state register
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata_o = st_r.rdata;
    assign output_a_o  = st_r.out_a;
    assign output_b_o  = st_r.out_b;

    // ==========================================================
    // assertions
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    idle_counter_a: assert property (
        !st_r.run |=> (st_r.cnt == `DOPWG_CNT_ZERO) && !st_r.phase_b)
        else $error("counter not held at zero while stopped");

    end_in_b_a: assert property (
        (cyc_end && split) |-> st_r.phase_b)
        else $error("cycle ended outside sub-cycle b");

    four_dead_a: assert property (
        (st_r.run && st_r.mode == MODE_FOUR && !st_r.phase_b &&
         st_r.cnt <= {1'b0, sa} + `DOPWG_ONE && !st_r.pol)
        |=> !output_a_o)
        else $error("output a active inside dead time");

    center_turn_a: assert property (
        (st_r.run && ctr && !st_r.down && at_top && !hold)
        |=> st_r.down ##1 (st_r.down || !st_r.run || !ctr))
        else $error("centered counter did not turn down at top");

    lock_hold_a: assert property (
        (st_r.run && st_r.lock && !st_r.alock_eff)
        |=> $stable(st_r.act_sb) && $stable(st_r.act_rb))
        else $error("update taken while locked");

    update_on_last_write_wait_a: assert property (
        (st_r.run && st_r.alock_eff && !st_r.last_rb)
        |=> $stable(st_r.act_rb))
        else $error("auto-lock loaded without reset-b last written");

    fifty_copy_a: assert property (
        (load && st_r.fifty) |=> (st_r.act_sa == st_r.act_sb))
        else $error("fifty percent copy missing");

    slot_step_a: assert property (
        cyc_end |=> (st_r.slot == $past(st_r.slot) + `DOPWG_SLOT_STEP))
        else $error("frame slot did not advance at cycle end");

    stretch_zero_a: assert property (
        hold |=> (st_r.cnt == `DOPWG_CNT_ZERO) && st_r.stretched)
        else $error("lengthening count not held at zero");

endmodule : dopwg_core

// ==== dopwg_defines.svh ====
/*
 * constants of the dual output waveform generator: register
 * addresses, field positions and counting offsets.
 * assumes: included by bare name after the package is compiled.
 */
`ifndef DOPWG_DEFINES_SVH
`define DOPWG_DEFINES_SVH

// ==========================================================
// register addresses
`define DOPWG_A_SET_A   3'h0
`define DOPWG_A_RST_A   3'h1
`define DOPWG_A_SET_B   3'h2
`define DOPWG_A_RST_B   3'h3
`define DOPWG_A_CFG     3'h4
`define DOPWG_A_OCFG    3'h5
`define DOPWG_A_MTX     3'h6
`define DOPWG_A_STAT    3'h7

// ==========================================================
// field positions
`define DOPWG_VAL_HI    11
`define DOPWG_FRAC_HI   15
`define DOPWG_FRAC_LO   12
`define DOPWG_MODE_HI   1
`define DOPWG_C_FIFTY   2
`define DOPWG_C_ENH     3
`define DOPWG_C_LOCK    4
`define DOPWG_C_ALOCK   5
`define DOPWG_C_POL     6
`define DOPWG_C_RUN     7
`define DOPWG_OCFG_HI   1
`define DOPWG_MTX_HI    3
`define DOPWG_O_A       0
`define DOPWG_O_B       1

// ==========================================================
// counting constants
`define DOPWG_ONE       13'h0001
`define DOPWG_CNT_ZERO  13'h0000
`define DOPWG_SLOT_STEP 4'h1

`endif

// ==== dopwg_pkg.sv ====
/*
 * types of the dual output waveform generator.
 * assumes: compiled before the generator module.
 */
package dopwg_pkg;

    // ==========================================================
    // bus types
    typedef logic [15:0] dopwg_word_t;
    typedef logic [2:0]  dopwg_addr_t;

    // ==========================================================
    // running modes
    typedef enum logic [1:0] {
        MODE_FOUR,
        MODE_TWO,
        MODE_ONE,
        MODE_CENTER
    } dopwg_mode_t;

    // ==========================================================
    // whole module state
    typedef struct packed {
        logic [15:0] pend_sa;
        logic [15:0] pend_sb;
        logic [15:0] pend_rb;
        logic [1:0]  pend_ocfg;
        logic [3:0]  pend_mtx;
        logic [15:0] act_sa;
        logic [15:0] act_sb;
        logic [15:0] act_rb;
        logic [1:0]  act_ocfg;
        logic [3:0]  act_mtx;
        logic [11:0] ra;
        dopwg_mode_t mode;
        logic        fifty;
        logic        enh;
        logic        lock;
        logic        alock;
        logic        alock_eff;
        logic        pol;
        logic        run;
        logic        dirty;
        logic        last_rb;
        logic [12:0] cnt;
        logic        down;
        logic        phase_b;
        logic [3:0]  slot;
        logic        stretched;
        logic        out_a;
        logic        out_b;
        logic [15:0] rdata;
    } dopwg_state_t;

endpackage : dopwg_pkg

// ==== dopwg_switch_model.sv ====
/*
 * far side model: two power switches whose gate pins are watched.
 * assumes: gates sampled on sys_clk_i, active high level conducts.
 */
`timescale 1ns/1ns

module dopwg_switch_model (
    // clock
    input  wire logic        sys_clk_i,
    // gate pins
    input  wire logic        gate_a_i,
    input  wire logic        gate_b_i,
    // conduction and switching counters
    output      logic [15:0] on_a_o,
    output      logic [15:0] on_b_o,
    output      logic [15:0] rise_b_o
);
    logic prev_b;

    // ==========================================================
    // counters wrap, so the bench only ever uses differences
    initial begin
        on_a_o = 16'h0000;
        on_b_o = 16'h0000;
        rise_b_o = 16'h0000;
        prev_b = 1'b0;
    end

    always @(posedge sys_clk_i) begin
        on_a_o <= on_a_o + 16'(gate_a_i);
        on_b_o <= on_b_o + 16'(gate_b_i);
        rise_b_o <= rise_b_o + 16'(gate_b_i & ~prev_b);
        prev_b <= gate_b_i;
    end
endmodule : dopwg_switch_model

// ==== dual_output_power_waveform_gen_bench.sv ====
/*
 * self-checking bench of the waveform generator: register tasks,
 * one task per scenario, pulse widths counted by the switch model.
 * assumes: design and switch model compiled before this file.
 */
`timescale 1ns/1ns
`include "dopwg_defines.svh"

module dual_output_power_waveform_gen_bench;
    import dopwg_pkg::*;
    logic        sys_clk_i;
    logic        rst_n_i;
    dopwg_addr_t addr;
    dopwg_word_t wdata;
    logic        wr_s;
    logic        rd_s;
    dopwg_word_t rdata;
    logic        out_a;
    logic        out_b;
    logic [15:0] on_a;
    logic [15:0] on_b;
    logic [15:0] rise_b;
    int          failures;
    int          checked;
    int          cycles;
    dopwg_word_t s;

    dopwg_core u_dut (
        .sys_clk_i   (sys_clk_i),
        .rst_n_i     (rst_n_i),
        .reg_addr_i  (addr),
        .reg_wdata_i (wdata),
        .reg_wr_i    (wr_s),
        .reg_rd_i    (rd_s),
        .reg_rdata_o (rdata),
        .output_a_o  (out_a),
        .output_b_o  (out_b)
    );

    dopwg_switch_model u_sw (
        .sys_clk_i (sys_clk_i),
        .gate_a_i  (out_a),
        .gate_b_i  (out_b),
        .on_a_o    (on_a),
        .on_b_o    (on_b),
        .rise_b_o  (rise_b)
    );

    // ==========================================================
    // clock and hang guard
    initial begin
        sys_clk_i = 1'b0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end

    always @(posedge sys_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 12000) begin
            failures++;
            finish_test();
        end
    end

    // ==========================================================
    // shared tasks
    task automatic check(input string nm, input dopwg_word_t seen, input dopwg_word_t exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic wr(input dopwg_addr_t a, input dopwg_word_t d);
        @(posedge sys_clk_i);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge sys_clk_i);
        wr_s <= 1'b0;
    endtask : wr

    task automatic rd(input dopwg_addr_t a, output dopwg_word_t d);
        @(posedge sys_clk_i);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge sys_clk_i);
        rd_s <= 1'b0;
        #1 d = rdata;
    endtask : rd

    // stop, load all values while stopped, then write the config c (which starts only if c sets run) and settle
    task automatic setup(input dopwg_word_t c, sa, ra, sb, rb);
        wr(`DOPWG_A_CFG, 16'h0000);
        wr(`DOPWG_A_SET_A, sa);
        wr(`DOPWG_A_RST_A, ra);
        wr(`DOPWG_A_SET_B, sb);
        wr(`DOPWG_A_RST_B, rb);
        wr(`DOPWG_A_OCFG, 16'h0003);
        wr(`DOPWG_A_CFG, c);
        repeat (40) @(posedge sys_clk_i);
    endtask : setup

    // window of whole periods, so the phase of the start is irrelevant
    task automatic wave(input string nm, input int n, input dopwg_word_t ea, eb);
        logic [15:0] a0;
        logic [15:0] b0;
        @(posedge sys_clk_i);
        #1 a0 = on_a;
        b0 = on_b;
        repeat (n) @(posedge sys_clk_i);
        #1 check({nm, " on a"}, on_a - a0, ea);
        check({nm, " on b"}, on_b - b0, eb);
    endtask : wave

    // ==========================================================
    // scenarios
    task automatic t_reset();
        rd(`DOPWG_A_CFG, s);
        check("config", s, 16'h0000);
        rd(`DOPWG_A_STAT, s);
        check("status", s, 16'h0000);
        check("pins", {14'h0000, out_b, out_a}, 16'h0000);
        $display("test reset done");
    endtask : t_reset

    task automatic t_regs();
        wr(`DOPWG_A_SET_A, 16'h1234);
        wr(`DOPWG_A_RST_A, 16'hF123);
        wr(`DOPWG_A_MTX, 16'h000F);
        rd(`DOPWG_A_SET_A, s);
        check("set a back", s, 16'h1234);
        @(posedge sys_clk_i);
        #1 check("rdata gone", rdata, 16'h0000);
        rd(`DOPWG_A_RST_A, s);
        check("reset a back", s, 16'h0123);
        rd(`DOPWG_A_MTX, s);
        check("matrix back", s, 16'h000F);
        $display("test registers done");
    endtask : t_regs

    task automatic t_modes();
        setup(16'h0080, 16'h0000, 16'h0003, 16'h0001, 16'h0002);
        wave("four", 100, 16'h001E, 16'h0014);
        setup(16'h0081, 16'h0000, 16'h0002, 16'h0000, 16'h0001);
        wave("two", 50, 16'h0014, 16'h000A);
        setup(16'h0082, 16'h0001, 16'h0003, 16'h0002, 16'h0005);
        wave("one", 60, 16'h0014, 16'h001E);
        setup(16'h0083, 16'h0002, 16'h0001, 16'h0003, 16'h0004);
        wave("center", 100, 16'h0028, 16'h0028);
        wr(`DOPWG_A_RST_A, 16'h0007);
        repeat (20) @(posedge sys_clk_i);
        wave("center ra", 100, 16'h0028, 16'h0028);
        wr(`DOPWG_A_RST_B, 16'h0006);
        repeat (40) @(posedge sys_clk_i);
        wave("center rb", 140, 16'h0028, 16'h0050);
        $display("test modes done");
    endtask : t_modes

    task automatic t_fifty();
        setup(16'h0085, 16'h0003, 16'h0003, 16'h0000, 16'h0001);
        wave("fifty", 40, 16'h000A, 16'h000A);
        $display("test fifty done");
    endtask : t_fifty

    task automatic t_lock();
        setup(16'h0091, 16'h0000, 16'h0002, 16'h0000, 16'h0001);
        wr(`DOPWG_A_RST_B, 16'h0003);
        wr(`DOPWG_A_MTX, 16'h0005);
        repeat (30) @(posedge sys_clk_i);
        rd(`DOPWG_A_STAT, s);
        check("held", {15'h0000, s[15]}, 16'h0001);
        rd(`DOPWG_A_MTX, s);
        check("matrix held", s, 16'h000F);
        wave("locked", 50, 16'h0014, 16'h000A);
        wr(`DOPWG_A_CFG, 16'h0081);
        repeat (30) @(posedge sys_clk_i);
        rd(`DOPWG_A_MTX, s);
        check("matrix moved", s, 16'h0005);
        wave("unlocked", 70, 16'h0014, 16'h001E);
        $display("test lock done");
    endtask : t_lock

    task automatic t_alock();
        setup(16'h0001, 16'h0000, 16'h0002, 16'h0000, 16'h0001);
        wr(`DOPWG_A_CFG, 16'h00A1);
        wr(`DOPWG_A_SET_B, 16'h0000);
        repeat (30) @(posedge sys_clk_i);
        rd(`DOPWG_A_STAT, s);
        check("alock late", {15'h0000, s[15]}, 16'h0000);
        wr(`DOPWG_A_CFG, 16'h00B1);
        wr(`DOPWG_A_RST_B, 16'h0003);
        wr(`DOPWG_A_SET_B, 16'h0001);
        repeat (30) @(posedge sys_clk_i);
        rd(`DOPWG_A_STAT, s);
        check("sb last", {15'h0000, s[15]}, 16'h0001);
        wr(`DOPWG_A_RST_B, 16'h0003);
        repeat (30) @(posedge sys_clk_i);
        rd(`DOPWG_A_STAT, s);
        check("rb last", {15'h0000, s[15]}, 16'h0000);
        wave("alock", 70, 16'h0014, 16'h0014);
        $display("test update_on_last_write done");
    endtask : t_alock

    task automatic t_pol();
        setup(16'h00C1, 16'h0000, 16'h0002, 16'h0000, 16'h0001);
        wave("low act", 50, 16'h001E, 16'h0028);
        $display("test polarity done");
    endtask : t_pol

    task automatic t_enh(input dopwg_word_t rb, input int frame);
        logic [15:0] a0;
        logic [15:0] r0;
        setup(16'h0089, 16'h0000, 16'h0002, 16'h0000, rb);
        @(posedge sys_clk_i);
        #1 a0 = on_a;
        r0 = rise_b;
        repeat (2 * frame) @(posedge sys_clk_i);
        #1 check("enh on a", on_a - a0, 16'h0040);
        check("enh cycles", rise_b - r0, 16'h0020);
        $display("test enhanced done");
    endtask : t_enh

    task automatic t_stop();
        setup(16'h0081, 16'h0000, 16'h0002, 16'h0000, 16'h0001);
        wr(`DOPWG_A_CFG, 16'h0001);
        repeat (5) @(posedge sys_clk_i);
        rd(`DOPWG_A_STAT, s);
        check("stopped", s, 16'h0000);
        check("idle pins", {14'h0000, out_b, out_a}, 16'h0000);
        wr(`DOPWG_A_CFG, 16'h0081);
        wave("restart", 50, 16'h0014, 16'h000A);
        $display("test stop done");
    endtask : t_stop

    // ==========================================================
    // verdict
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        failures = 0;
        checked = 0;
        rst_n_i = 1'b0;
        addr = 3'h0;
        wdata = 16'h0000;
        wr_s = 1'b0;
        rd_s = 1'b0;
        repeat (16) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_regs();
        t_modes();
        t_fifty();
        t_lock();
        t_alock();
        t_pol();
        t_enh(16'h4001, 84);
        t_enh(16'hF001, 95);
        t_stop();
        finish_test();
    end
endmodule : dual_output_power_waveform_gen_bench
